// file: design/flp_pkg.sv
// Shared constants and carrier types for the flash lock and security-register block.
// Assumes a 20 MHz reference clock that oversamples the SPI pins.
package flp_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 50;
  localparam int OTP_PROG_TIME_NS   = 500000;   // Plain default, no figure given
  localparam int OTP_PROG_CYCLES    = (OTP_PROG_TIME_NS / CLK_PERIOD_NS < 1) ? 1
                                      : OTP_PROG_TIME_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Opcodes and frame layout
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_OTP_PROG  = 8'h9B;
  localparam logic [7:0] OP_WR_ENABLE = 8'h06;
  localparam logic [2:0] BYTES_HEADER = 3'h4;   // Opcode plus three address bytes
  localparam logic [2:0] BYTES_OPCODE = 3'h1;

  // ----------------------------------------------------------------
  // Security register geometry
  // ----------------------------------------------------------------
  localparam int USER_BYTES = 64;
  localparam int OTP_BYTES  = 128;
  localparam int BUF_BYTES  = 256;
  localparam logic [7:0] ERASED_BYTE  = 8'hFF;
  localparam logic [7:0] FACTORY_SEED = 8'h5A;  // Arbitrary value

  // ----------------------------------------------------------------
  // Status write fields and reset values
  // ----------------------------------------------------------------
  localparam int LOCK_BIT_POS = 7;
  localparam int GLB_HI_POS   = 5;
  localparam int GLB_LO_POS   = 2;
  localparam logic [3:0] GLB_UNPROTECT = 4'h0;
  localparam logic [3:0] GLB_PROTECT   = 4'hF;
  localparam logic LOCK_RST   = 1'b0;
  localparam logic WEL_RST    = 1'b0;
  localparam logic SECT_RST   = 1'b1;
  localparam logic [1:0] SWP_NONE = 2'h0;
  localparam logic [1:0] SWP_SOME = 2'h1;
  localparam logic [1:0] SWP_ALL  = 2'h3;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
  } flp_spi_s;

  typedef struct packed {
    logic       lock;
    logic       seq_mode;
    logic       prog_err;
    logic       wp_pin;
    logic [1:0] swp;
    logic       write_enable_latch;
    logic       busy;
  } flp_status_s;

endpackage

// file: design/flp_mem.sv
// Simple dual-port byte memory with registered read data.
// Assumes write and read share one clock; the array itself has no reset.
`timescale 1ns/100ps
`default_nettype none
module flp_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 256
) (
  input  wire logic                     i_clk,    // Clock
  input  wire logic                     i_we,     // Write strobe
  input  wire logic [$clog2(DEPTH)-1:0] i_waddr,  // Write address
  input  wire logic [WIDTH-1:0]         i_wdata,  // Write data
  input  wire logic [$clog2(DEPTH)-1:0] i_raddr,  // Read address
  output logic      [WIDTH-1:0]         o_rdata   // Read data, one cycle later
);

  logic [WIDTH-1:0] mem_r [DEPTH];

  always_ff @(posedge i_clk)
  begin
    if (i_we)
    begin
      mem_r[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk)
  begin
    o_rdata <= mem_r[i_raddr];
  end

endmodule // flp_mem
`default_nettype wire

// file: design/flp_lock_otp.sv
// Sector-protection locking and one-time security register programming.
// Assumes SPI pins and the write-protect pin are asynchronous to i_ref_clk,
// and that the status write and sector strobes come from same-clock decode logic.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Hardware lock: pin low and lock set
// - Hardware lock ignores protect and status writes
// - Clearing lock skips same-write global operation
// - Pin low: lock clears only by reset
// - Pin high: lock may still be set
// - Setting lock also applies global operation
// - Sector protected when its register is one
// - Software lock: may clear, no changes
// - 128 bytes: 64 user, 64 fixed
// - No erase, whole area, program once per reset
// - Opcode, three address bytes, then data
// - Only six low address bits used
// - Wrap past end; unsent bytes stay erased
// - Over 64 bytes keeps last 64
// - Chip select rise starts timed program
// - Abort on short or misaligned frame
// - Aborts clear the write enable latch
// - Status stays readable, shows busy
// - Write enable clears before program completes
// - Command reuses shared 256-byte page buffer
// - Lock bit clears on reset
// - Status bit zero shows busy
// - Status bit one shows write enable
module flp_lock_otp #(
  parameter int SECTORS     = 8,
  parameter int PROG_CYCLES = flp_pkg::OTP_PROG_CYCLES
) (
  input  wire logic                           i_ref_clk,     // 20 MHz reference clock
  input  wire logic                           i_rstn,        // Async reset, active low
  input  wire flp_pkg::flp_spi_s              i_spi,         // SPI chip select, clock, data in
  input  wire logic                           i_wp_n,        // Write-protect pin, active low
  input  wire logic                           i_wrsr_stb,    // Status write strobe
  input  wire logic [7:0]                     i_wrsr_data,   // Status write data byte
  input  wire logic                           i_psec_stb,    // Protect-sector strobe
  input  wire logic                           i_usec_stb,    // Unprotect-sector strobe
  input  wire logic [$clog2(SECTORS)-1:0]     i_sec_idx,     // Sector for the strobes
  input  wire logic                           i_wel_clr,     // Clear write enable from other commands
  input  wire logic [6:0]                     i_otp_addr,    // Security register read address
  output flp_pkg::flp_status_s                o_status,      // Status byte
  output logic      [SECTORS-1:0]             o_sector_prot, // Sector protection registers
  output logic                                o_hw_locked,   // Hardware locking active
  output logic      [7:0]                     o_otp_data     // Security register read data
);

  localparam int TW = $clog2(PROG_CYCLES + 1);
  localparam logic [TW-1:0] PROG_LAST = TW'(PROG_CYCLES - 1);
  localparam logic [5:0]    IDX_LAST  = 6'(flp_pkg::USER_BYTES - 1);

  typedef enum logic [1:0] {ST_IDLE, ST_WALK, ST_HOLD} flp_prog_e;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  flp_pkg::flp_spi_s spi_m_r;
  flp_pkg::flp_spi_s spi_s_r;
  logic              wp_m_r;
  logic              wp_s_r;
  logic              sck_d_r;
  logic              cs_d_r;

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      spi_m_r <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
      spi_s_r <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
      wp_m_r  <= 1'b1;
      wp_s_r  <= 1'b1;
      sck_d_r <= 1'b0;
      cs_d_r  <= 1'b1;
    end
    else
    begin
      spi_m_r <= i_spi;
      spi_s_r <= spi_m_r;
      wp_m_r  <= i_wp_n;
      wp_s_r  <= wp_m_r;
      sck_d_r <= spi_s_r.sck;
      cs_d_r  <= spi_s_r.cs_n;
    end
  end

  logic sck_rise;
  logic cs_fall;
  logic cs_rise;
  assign sck_rise = spi_s_r.sck & ~sck_d_r & ~spi_s_r.cs_n;
  assign cs_fall  = ~spi_s_r.cs_n & cs_d_r;
  assign cs_rise  = spi_s_r.cs_n & ~cs_d_r;

  // ----------------------------------------------------------------
  // Shared state
  // ----------------------------------------------------------------
  flp_prog_e        state_r;
  logic             busy;
  logic             lock_r;
  logic             wel_r;
  logic             hw_lock;
  logic             otp_done_r;
  logic [TW-1:0]    timer_r;
  logic [5:0]       walk_idx_r;
  logic             pend_r;
  logic [5:0]       wr_idx_r;

  assign busy    = (state_r != ST_IDLE);
  assign hw_lock = ~wp_s_r & lock_r;

  // ----------------------------------------------------------------
  // Frame capture
  // ----------------------------------------------------------------
  logic        frame_ok_r;
  logic [2:0]  bit_r;
  logic [2:0]  byte_cnt_r;
  logic [6:0]  shift_r;
  logic [7:0]  opcode_r;
  logic [5:0]  start_r;
  logic [5:0]  dcnt_r;
  logic        has_data_r;
  logic [63:0] mask_r;
  logic        byte_done;
  logic [7:0]  byte_val;
  logic        buf_we;
  logic [5:0]  data_idx;

  assign byte_done = sck_rise & frame_ok_r & (bit_r == 3'h7);
  assign byte_val  = {shift_r, spi_s_r.si};
  assign data_idx  = 6'(start_r + dcnt_r);
  assign buf_we    = byte_done & (byte_cnt_r == flp_pkg::BYTES_HEADER)
                   & (opcode_r == flp_pkg::OP_OTP_PROG);

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      frame_ok_r <= 1'b0;
      bit_r      <= 3'h0;
      byte_cnt_r <= 3'h0;
      shift_r    <= 7'h00;
      opcode_r   <= 8'h00;
      start_r    <= 6'h00;
      dcnt_r     <= 6'h00;
      has_data_r <= 1'b0;
      mask_r     <= 64'h0000_0000_0000_0000;
    end
    else if (cs_fall)
    begin
      // Frames opened during a program cycle are ignored whole
      frame_ok_r <= ~busy;
      bit_r      <= 3'h0;
      byte_cnt_r <= 3'h0;
      dcnt_r     <= 6'h00;
      has_data_r <= 1'b0;
      if (!busy)
      begin
        mask_r <= 64'h0000_0000_0000_0000;
      end
    end
    else if (sck_rise && frame_ok_r)
    begin
      shift_r <= byte_val[6:0];
      bit_r   <= 3'(bit_r + 3'h1);
      if (bit_r == 3'h7)
      begin
        if (byte_cnt_r != flp_pkg::BYTES_HEADER)
        begin
          byte_cnt_r <= 3'(byte_cnt_r + 3'h1);
        end
        if (byte_cnt_r == 3'h0)
        begin
          opcode_r <= byte_val;
        end
        if (byte_cnt_r == 3'h3)
        begin
          start_r <= byte_val[5:0];
        end
        if (buf_we)
        begin
          dcnt_r           <= 6'(dcnt_r + 6'h01);
          has_data_r       <= 1'b1;
          mask_r[data_idx] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // End-of-frame decisions
  // ----------------------------------------------------------------
  logic frame_end;
  logic is_otp;
  logic aligned;
  logic wren_ok;
  logic prog_start;
  logic prog_abort;

  assign frame_end  = cs_rise & frame_ok_r & ~busy;
  assign is_otp     = (byte_cnt_r >= flp_pkg::BYTES_OPCODE) & (opcode_r == flp_pkg::OP_OTP_PROG);
  assign aligned    = (bit_r == 3'h0) & has_data_r;
  assign wren_ok    = frame_end & (byte_cnt_r == flp_pkg::BYTES_OPCODE) & (bit_r == 3'h0)
                    & (opcode_r == flp_pkg::OP_WR_ENABLE);
  // Without write enable the command is simply not acted on
  assign prog_start = frame_end & is_otp & wel_r & aligned & ~otp_done_r;
  assign prog_abort = frame_end & is_otp & wel_r & (~aligned | otp_done_r);

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wel_r <= flp_pkg::WEL_RST;
    end
    else if (prog_start || prog_abort || i_wel_clr)
    begin
      // Cleared at program start, well before the cycle ends
      wel_r <= 1'b0;
    end
    else if (wren_ok)
    begin
      wel_r <= 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      otp_done_r <= 1'b0;
    end
    else if (prog_start)
    begin
      otp_done_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Self-timed program of the user area
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_r    <= ST_IDLE;
      timer_r    <= '0;
      walk_idx_r <= 6'h00;
      pend_r     <= 1'b0;
      wr_idx_r   <= 6'h00;
    end
    else
    begin
      pend_r   <= (state_r == ST_WALK);
      wr_idx_r <= walk_idx_r;
      case (state_r)
        ST_IDLE:
        begin
          timer_r    <= '0;
          walk_idx_r <= 6'h00;
          if (prog_start)
          begin
            state_r <= ST_WALK;
          end
        end
        ST_WALK:
        begin
          timer_r    <= TW'(timer_r + 1'b1);
          walk_idx_r <= 6'(walk_idx_r + 6'h01);
          if (walk_idx_r == IDX_LAST)
          begin
            state_r <= ST_HOLD;
          end
        end
        ST_HOLD:
        begin
          timer_r <= TW'(timer_r + 1'b1);
          if (timer_r >= PROG_LAST)
          begin
            state_r <= ST_IDLE;
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Page buffer and security register storage
  // ----------------------------------------------------------------
  logic [7:0] buf_rdata;
  logic [7:0] otp_rdata;
  logic [7:0] otp_wdata;

  // Buffer is the shared page buffer, so earlier page data is lost
  flp_mem #(
    .WIDTH (8),
    .DEPTH (flp_pkg::BUF_BYTES)
  ) u_page_buf (
    .i_clk   (i_ref_clk),
    .i_we    (buf_we),
    .i_waddr ({2'b00, data_idx}),
    .i_wdata (byte_val),
    .i_raddr ({2'b00, walk_idx_r}),
    .o_rdata (buf_rdata)
  );

  // Locations without data are written erased, same as never touched
  assign otp_wdata = mask_r[wr_idx_r] ? buf_rdata : flp_pkg::ERASED_BYTE;

  flp_mem #(
    .WIDTH (8),
    .DEPTH (flp_pkg::USER_BYTES)
  ) u_otp_user (
    .i_clk   (i_ref_clk),
    .i_we    (pend_r),
    .i_waddr (wr_idx_r),
    .i_wdata (otp_wdata),
    .i_raddr (i_otp_addr[5:0]),
    .o_rdata (otp_rdata)
  );

  logic [6:0] otp_addr_d_r;

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      otp_addr_d_r <= 7'h00;
      o_otp_data   <= flp_pkg::ERASED_BYTE;
    end
    else
    begin
      otp_addr_d_r <= i_otp_addr;
      if (otp_addr_d_r[6])
      begin
        // Fixed upper half has no write path at all
        o_otp_data <= flp_pkg::FACTORY_SEED ^ {1'b0, otp_addr_d_r};
      end
      else if (otp_done_r && !busy)
      begin
        o_otp_data <= otp_rdata;
      end
      else
      begin
        o_otp_data <= flp_pkg::ERASED_BYTE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Lock bit and sector protection registers
  // ----------------------------------------------------------------
  logic       wrsr_ok;
  logic [3:0] glb_code;
  logic       glb_prot;
  logic       glb_unprot;
  logic       sec_ok;

  assign wrsr_ok    = i_wrsr_stb & ~hw_lock & ~busy;
  assign glb_code   = i_wrsr_data[flp_pkg::GLB_HI_POS:flp_pkg::GLB_LO_POS];
  // Globals only while unlocked; a clearing write leaves sectors alone
  assign glb_prot   = wrsr_ok & ~lock_r & (glb_code == flp_pkg::GLB_PROTECT);
  assign glb_unprot = wrsr_ok & ~lock_r & (glb_code == flp_pkg::GLB_UNPROTECT);
  assign sec_ok     = ~lock_r & ~busy;

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      lock_r <= flp_pkg::LOCK_RST;
    end
    else if (wrsr_ok)
    begin
      lock_r <= i_wrsr_data[flp_pkg::LOCK_BIT_POS];
    end
  end

  genvar g;
  generate
    for (g = 0; g < SECTORS; g++)
    begin : g_sector
      always_ff @(posedge i_ref_clk or negedge i_rstn)
      begin
        if (!i_rstn)
        begin
          o_sector_prot[g] <= flp_pkg::SECT_RST;
        end
        else if (glb_prot)
        begin
          o_sector_prot[g] <= 1'b1;
        end
        else if (glb_unprot)
        begin
          o_sector_prot[g] <= 1'b0;
        end
        else if (sec_ok && i_psec_stb && (i_sec_idx == g))
        begin
          o_sector_prot[g] <= 1'b1;
        end
        else if (sec_ok && i_usec_stb && (i_sec_idx == g))
        begin
          o_sector_prot[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  logic [1:0] swp;

  always_comb
  begin
    if (&o_sector_prot)
    begin
      swp = flp_pkg::SWP_ALL;
    end
    else if (|o_sector_prot)
    begin
      swp = flp_pkg::SWP_SOME;
    end
    else
    begin
      swp = flp_pkg::SWP_NONE;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_status    <= '0;
      o_hw_locked <= 1'b0;
    end
    else
    begin
      o_status.lock     <= lock_r;
      o_status.seq_mode <= 1'b0;
      o_status.prog_err <= 1'b0;
      o_status.wp_pin   <= wp_s_r;
      o_status.swp      <= swp;
      o_status.write_enable_latch      <= wel_r;
      o_status.busy     <= busy;
      o_hw_locked       <= hw_lock;
    end
  end

endmodule // flp_lock_otp
`default_nettype wire

// file: bench/flp_lock_otp_sva.sv
// Checker on the ports of the lock and security-register block.
// Assumes it is bound to flp_lock_otp; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module flp_lock_otp_sva #(
  parameter int SECTORS     = 8,
  parameter int PROG_CYCLES = flp_pkg::OTP_PROG_CYCLES
) (
  input wire logic                 i_ref_clk,     // Clock
  input wire logic                 i_rstn,        // Reset, active low
  input wire flp_pkg::flp_spi_s    i_spi,         // SPI pins
  input wire logic                 i_wrsr_stb,    // Status write
  input wire logic                 i_psec_stb,    // Protect sector
  input wire logic                 i_usec_stb,    // Unprotect sector
  input wire logic [6:0]           i_otp_addr,    // Read address
  input wire flp_pkg::flp_status_s o_status,      // Status byte
  input wire logic [SECTORS-1:0]   o_sector_prot, // Sector registers
  input wire logic                 o_hw_locked,   // Hardware lock
  input wire logic [7:0]           o_otp_data     // Read data
);
  localparam int BUSY_MAX = PROG_CYCLES + 4;
  localparam int BUSY_MIN = PROG_CYCLES - 2;
  logic [15:0] busy_cnt_r;
  logic [1:0]  age_r;

  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  // Age guards the read pipeline, which still holds reset values
  always_ff @(posedge i_ref_clk or negedge i_rstn)
    if (!i_rstn)
      age_r <= 2'h0;
    else if (age_r != 2'h3)
      age_r <= age_r + 2'h1;
  always_ff @(posedge i_ref_clk or negedge i_rstn)
    if (!i_rstn)
      busy_cnt_r <= 16'h0000;
    else
      busy_cnt_r <= o_status.busy ? busy_cnt_r + 16'h0001 : 16'h0000;

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  property p_hw_lock; o_hw_locked && $past(o_hw_locked) |-> o_status.lock; endproperty
  a_hw_lock: assert property (p_hw_lock) else $error("hardware lock without lock bit");
  property p_freeze;
    $past(o_hw_locked, 2) && $past(o_hw_locked) && o_hw_locked |-> $stable(o_sector_prot) && $stable(o_status.lock);
  endproperty
  a_freeze: assert property (p_freeze) else $error("locked state changed");
  property p_wel_busy; o_status.busy |-> !o_status.write_enable_latch; endproperty
  a_wel_busy: assert property (p_wel_busy) else $error("write enable set while busy");
  property p_busy_max; busy_cnt_r <= BUSY_MAX; endproperty
  a_busy_max: assert property (p_busy_max) else $error("program too long");
  property p_busy_min; $fell(o_status.busy) |-> busy_cnt_r >= BUSY_MIN; endproperty
  a_busy_min: assert property (p_busy_min) else $error("program too short");
  property p_sec_cause;
    o_sector_prot != $past(o_sector_prot) |-> $past(i_psec_stb | i_usec_stb | i_wrsr_stb);
  endproperty
  a_sec_cause: assert property (p_sec_cause) else $error("sector change without command");
  property p_unlock; $fell(o_status.lock) |-> $past(o_sector_prot) == $past(o_sector_prot, 2); endproperty
  a_unlock: assert property (p_unlock) else $error("global applied on unlock");
  property p_wel_rise; $rose(o_status.write_enable_latch) |-> i_spi.cs_n && $past(i_spi.cs_n, 2) && !o_status.busy; endproperty
  a_wel_rise: assert property (p_wel_rise) else $error("write enable rose mid frame");
  property p_rst_vals; $rose(i_rstn) |-> !o_status.lock && !o_status.write_enable_latch && (&o_sector_prot); endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("bad values after reset");
  property p_factory;
    age_r == 2'h3 && $past(i_otp_addr, 2) >= 7'h40
      |-> o_otp_data == (flp_pkg::FACTORY_SEED ^ {1'b0, $past(i_otp_addr, 2)});
  endproperty
  a_factory: assert property (p_factory) else $error("factory byte altered");
  c_prog: cover property ($rose(o_status.busy));
  c_hw: cover property ($rose(o_hw_locked));
  c_unlock: cover property ($fell(o_status.lock));
endmodule // flp_lock_otp_sva
`default_nettype wire

// file: bench/flp_spi_host.sv
// SPI host model that sends command frames to the block.
// Assumes mode 0: the clock idles low and stands still between frames.
`timescale 1ns/100ps
`default_nettype none
module flp_spi_host (
  output var flp_pkg::flp_spi_s o_spi // SPI pins to the device
);
  initial o_spi = 3'b100;
  // Short bit counts give ragged frames on purpose
  task automatic send(input logic [7:0] q[$], input int nbits);
    logic b;
    b = 1'b0;
    #7 o_spi.cs_n = 1'b0;
    #200;
    for (int i = 0; i < nbits; i++)
    begin
      b = q[i / 8][7 - i % 8];
      o_spi.si = b;
      #200 o_spi.sck = 1'b1;
      #200 o_spi.sck = 1'b0;
    end
    #200 o_spi.cs_n = 1'b1;
    // Released line shows the inverse, not a stale value
    o_spi.si = ~b;
    #400;
  endtask
endmodule // flp_spi_host
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the lock and security-register block.
// Assumes the SPI host model and the checker bound below.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int PROG = 100;
  localparam int SEC  = 8;
  logic                 clk;
  logic                 rstn;
  logic                 wp_n;
  logic                 wr_stb;
  logic [7:0]           wr_data;
  logic                 ps_stb;
  logic                 us_stb;
  logic [2:0]           sidx;
  logic                 wel_clr;
  logic [6:0]           oaddr;
  flp_pkg::flp_spi_s    spi;
  flp_pkg::flp_status_s st;
  logic [SEC-1:0]       sprot;
  logic                 hwl;
  logic [7:0]           odata;
  int                   mismatches;
  int                   total_checks;
  int                   cycles;
  int                   seed;
  int                   m_lock;
  int                   m_wel;
  int                   m_done;
  logic [SEC-1:0]       m_sec;
  int                   m_otp[64];
  logic [7:0]           fq[$];
  logic [31:0]          r;
  logic [8:0]           tbl[11];

  flp_lock_otp #(.SECTORS(SEC), .PROG_CYCLES(PROG)) flp_lock_otp_i (
    .i_ref_clk(clk), .i_rstn(rstn), .i_spi(spi), .i_wp_n(wp_n), .i_wrsr_stb(wr_stb),
    .i_wrsr_data(wr_data), .i_psec_stb(ps_stb), .i_usec_stb(us_stb), .i_sec_idx(sidx),
    .i_wel_clr(wel_clr), .i_otp_addr(oaddr), .o_status(st), .o_sector_prot(sprot),
    .o_hw_locked(hwl), .o_otp_data(odata));
  flp_spi_host flp_spi_host_i (.o_spi(spi));

  // ----------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic test_done();
    $display("TB: mismatches=%0d total_checks=%0d", mismatches, total_checks);
    if (mismatches == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      mismatches++;
      $display("Error at %0t: run timed out", $time);
      test_done();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic fail(input string msg);
    mismatches++;
    $display("Error at %0t: %s", $time, msg);
  endtask
  task automatic chk_prot();
    total_checks++;
    if (st.lock !== m_lock[0] || sprot !== m_sec || hwl !== (!wp_n && m_lock == 1) || st.wp_pin !== wp_n
        || st.seq_mode !== 1'b0 || st.prog_err !== 1'b0
        || st.swp !== (&m_sec ? flp_pkg::SWP_ALL : (|m_sec ? flp_pkg::SWP_SOME : flp_pkg::SWP_NONE)))
      fail("lock or sector state");
  endtask
  task automatic chk_wel();
    total_checks++;
    if (st.write_enable_latch !== m_wel[0])
      fail("write enable latch");
  endtask
  task automatic chk_otp();
    logic [7:0] e;
    for (int a = 0; a < 128; a++)
    begin
      oaddr = 7'(a);
      tick(2);
      e = (a < 64) ? 8'(m_otp[a]) : (flp_pkg::FACTORY_SEED ^ 8'(a));
      total_checks++;
      if (odata !== e)
        fail("security byte");
    end
  endtask
  task automatic do_reset();
    rstn = 1'b0;
    tick(10);
    rstn = 1'b1;
    tick(4);
    m_lock = 0;
    m_wel = 0;
    m_done = 0;
    m_sec = '1;
    foreach (m_otp[i]) m_otp[i] = 255;
  endtask
  task automatic wr_sr(input logic [7:0] d);
    wr_data = d;
    wr_stb = 1'b1;
    tick(1);
    wr_stb = 1'b0;
    if (!(wp_n == 1'b0 && m_lock == 1))
    begin
      if (m_lock == 0 && d[5:2] == 4'h0)
        m_sec = '0;
      if (m_lock == 0 && d[5:2] == 4'hF)
        m_sec = '1;
      m_lock = d[7];
    end
    tick(3);
  endtask
  task automatic sec_op(input logic p, input logic [2:0] ix);
    ps_stb = p;
    us_stb = !p;
    sidx = ix;
    tick(1);
    ps_stb = 1'b0;
    us_stb = 1'b0;
    if (m_lock == 0)
      m_sec[ix] = p;
    tick(3);
  endtask
  // Sends a frame and applies the same frame to the model
  task automatic frame(input int nbits);
    flp_spi_host_i.send(fq, nbits);
    if (fq[0] == flp_pkg::OP_WR_ENABLE && nbits == 8)
      m_wel = 1;
    else if (fq[0] == flp_pkg::OP_OTP_PROG && m_wel == 1)
    begin
      m_wel = 0;
      if (nbits >= 40 && nbits % 8 == 0 && m_done == 0)
      begin
        m_done = 2;
        for (int i = 4; i < nbits / 8; i++)
          m_otp[(int'(fq[3][5:0]) + i - 4) % 64] = fq[i];
      end
    end
    tick(8);
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    total_checks++;
    if (st.busy !== 1'b1)
      fail("busy not shown");
    while (st.busy !== 1'b0 && n < PROG + 50)
    begin
      tick(1);
      n++;
    end
    if (n >= PROG + 50)
      fail("busy never cleared");
    m_done = 1;
  endtask
  task automatic we();
    fq = {flp_pkg::OP_WR_ENABLE};
    frame(8);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    seed = 32'h1cdaae0c;
    {rstn, wp_n, wr_stb, wr_data, ps_stb, us_stb, sidx, wel_clr, oaddr} = 24'h40_0000;
    tbl = '{9'h100, 9'h1F0, 9'h13C, 9'h17F, 9'h183, 9'h00F, 9'h07C, 9'h10F, 9'h1FF, 9'h000, 9'h17F};
    do_reset();
    chk_prot();
    // Status writes across lock states, each followed by a random sector command
    foreach (tbl[k])
    begin
      r = $random(seed);
      if (wp_n !== tbl[k][8])
      begin
        wp_n = tbl[k][8];
        tick(4);
      end
      wr_sr(tbl[k][7:0]);
      chk_prot();
      sec_op(r[3], r[2:0]);
      chk_prot();
    end
    fq = {8'h9B, 8'h00, 8'h00, 8'h00, 8'h11};
    frame(40);
    chk_wel();
    we();
    chk_wel();
    wel_clr = 1'b1;
    tick(1);
    wel_clr = 1'b0;
    m_wel = 0;
    tick(2);
    chk_wel();
    we();
    fq = {8'h9B, 8'h00, 8'h00};
    frame(24);
    chk_wel();
    we();
    fq = {8'h9B, 8'h00, 8'h00, 8'h3E, 8'hD0, 8'h55};
    frame(43);
    chk_wel();
    we();
    r = $random(seed);
    fq = {8'h9B, 8'h00, 8'h00, 8'h3E, r[7:0], r[15:8], r[23:16]};
    frame(56);
    chk_wel();
    wait_ready();
    chk_otp();
    we();
    fq = {8'h9B, 8'h00, 8'h00, 8'h00, 8'hAA};
    frame(40);
    chk_wel();
    chk_otp();
    do_reset();
    chk_prot();
    we();
    fq = {8'h9B, 8'hFF, 8'hFF, 8'hC5};
    repeat (70) fq.push_back(8'($random(seed)));
    frame(74 * 8);
    wait_ready();
    chk_otp();
    test_done();
  end
endmodule // testbench

bind flp_lock_otp flp_lock_otp_sva #(.SECTORS(SECTORS), .PROG_CYCLES(PROG_CYCLES)) chk_i (
  .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_spi(i_spi), .i_wrsr_stb(i_wrsr_stb),
  .i_psec_stb(i_psec_stb), .i_usec_stb(i_usec_stb), .i_otp_addr(i_otp_addr), .o_status(o_status),
  .o_sector_prot(o_sector_prot), .o_hw_locked(o_hw_locked), .o_otp_data(o_otp_data));
`default_nettype wire
